// *** hdl/fps_flash_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - One cycle after reset release load protection register from nonvolatile protection byte.
// - Protection readable; with disable 0 writes only lower the select.
// - With disable 1, software writes leave protection unchanged.
// - Debug writes change protection bits without restriction.
// - Bits 7:1 select boundary; protected region at flash top.
// - Erase or program inside protected region is refused.
// - Bit 0 disables protection: 0 protects, 1 protects nothing.
// - Buffer empty: write 1 launches; clears when burst is queued; burst transfer sets.
// - Only burst program may be queued, and only behind an active burst.
// - Complete sets when idle and empty; clears on launch; not writable.
// - Protect violation sets on protected target; command dropped; w1c.
// - Access error on bad sequence, no divider, or stop mid-command.
// - Access error cleared by writing 1; writing 0 does nothing.
// - Blank sets when blank check finds all 0xff; clears on launch.
// - Codes: blank check 0x05, page erase 0x40, mass erase 0x41.
// - Code 0x20 byte program, 0x25 burst program, bufferable.
// - Any other code is illegal and sets access error.
// - Successful blank check sets security code to unsecured.
`include "fps_defs.svh"

module fps_flash_ctrl
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Nonvolatile protection byte and stop request
   input wire logic [7:0] nonvolatile_protect_byte,
   input wire logic stop_req,
   // Flash array side
   output logic arr_start,
   output fps_pkg::fps_op_type arr_op,
   output logic [15:0] arr_addr,
   output logic [7:0] arr_data,
   input wire logic arr_done,
   input wire logic arr_blank_ok,
   // Security state
   output logic [1:0] security_state_code
);
   import fps_pkg::*;

   fps_state_type state_r, state_nxt;
   logic load_r, load_nxt;
   logic [7:0] prot_r, prot_nxt;
   logic [7:0] stat_r, stat_nxt;
   logic [7:0] cmd_code_reg, cmd_nxt;
   logic [7:0] div_r, div_nxt;
   logic div_ld_r, div_ld_nxt;
   logic [15:0] tgt_r, tgt_nxt;
   logic [7:0] dat_r, dat_nxt;
   logic pend_r, pend_nxt;
   fps_op_type pend_op_r, pend_op_nxt;
   logic [15:0] pend_a_r, pend_a_nxt;
   logic [7:0] pend_d_r, pend_d_nxt;
   logic start_r, start_nxt;
   fps_op_type op_r, op_nxt;
   logic [15:0] a_r, a_nxt;
   logic [7:0] d_r, d_nxt;
   logic [1:0] sec_r, sec_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic rdy_r, rdy_nxt;
   logic err_r, err_nxt;
   logic stop_s1_r, stop_s2_r;

   logic wr, rd, hit;
   logic [15:0] bound;
   logic prot_hit;
   fps_op_type dec;

   assign wr = psel && penable && pwrite && !rdy_r;
   assign rd = psel && penable && !pwrite && !rdy_r;

   // Protected region: addresses above boundary select, top of flash
   assign bound = {1'b1, prot_r[7:1], 8'hff};
   assign prot_hit = !prot_r[`FPS_PROT_DIS] && (tgt_r > bound);

   always_comb
   begin
      unique case (cmd_code_reg)
         `FPS_CMD_BLANK: dec = FPS_OP_BLANK;
         `FPS_CMD_BYTE: dec = FPS_OP_BYTE;
         `FPS_CMD_BURST: dec = FPS_OP_BURST;
         `FPS_CMD_PAGE: dec = FPS_OP_PAGE;
         `FPS_CMD_MASS: dec = FPS_OP_MASS;
         default: dec = FPS_OP_BAD;
      endcase
   end

   // Stop request is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
      end
      else
      begin
         stop_s1_r <= stop_req;
         stop_s2_r <= stop_s1_r;
      end
   end

   always_comb
   begin
      logic launch;
      logic reject;
      logic mass_or_blank;
      launch = 1'b0;
      reject = 1'b0;
      mass_or_blank = 1'b0;
      state_nxt = state_r;
      load_nxt = 1'b0;
      prot_nxt = prot_r;
      stat_nxt = stat_r;
      cmd_nxt = cmd_code_reg;
      div_nxt = div_r;
      div_ld_nxt = div_ld_r;
      tgt_nxt = tgt_r;
      dat_nxt = dat_r;
      pend_nxt = pend_r;
      pend_op_nxt = pend_op_r;
      pend_a_nxt = pend_a_r;
      pend_d_nxt = pend_d_r;
      start_nxt = 1'b0;
      op_nxt = op_r;
      a_nxt = a_r;
      d_nxt = d_r;
      sec_nxt = sec_r;
      rd_nxt = rd_r;
      rdy_nxt = 1'b0;
      err_nxt = 1'b0;
      hit = 1'b1;

      // Capture strap one cycle after reset release
      if (load_r)
         prot_nxt = nonvolatile_protect_byte;

      if (psel && penable && !rdy_r)
      begin
         rdy_nxt = 1'b1;
         unique case (paddr)
            `FPS_ADDR_PROT, `FPS_ADDR_STAT, `FPS_ADDR_CMD, `FPS_ADDR_DIV,
            `FPS_ADDR_TGT, `FPS_ADDR_OPT, `FPS_ADDR_DBG, `FPS_ADDR_CTL:
               hit = 1'b1;
            default: hit = 1'b0;
         endcase
         err_nxt = !hit;
      end

      if (rd)
      begin
         unique case (paddr)
            `FPS_ADDR_PROT: rd_nxt = {24'h0, prot_r};
            `FPS_ADDR_STAT: rd_nxt = {24'h0, stat_r};
            `FPS_ADDR_CMD: rd_nxt = {24'h0, cmd_code_reg};
            `FPS_ADDR_DIV: rd_nxt = {24'h0, div_ld_r, div_r[6:0]};
            `FPS_ADDR_TGT: rd_nxt = {16'h0, tgt_r};
            `FPS_ADDR_OPT: rd_nxt = {30'h0, sec_r};
            `FPS_ADDR_CTL: rd_nxt = {24'h0, dat_r};
            default: rd_nxt = 32'h0;
         endcase
      end

      if (wr)
      begin
         unique case (paddr)
            `FPS_ADDR_PROT:
               // Smaller select only; disable bit is left unchanged
               if (!prot_r[`FPS_PROT_DIS] && !load_r)
               begin
                  if (pwdata[7:1] < prot_r[7:1])
                     prot_nxt[7:1] = pwdata[7:1];
               end
            `FPS_ADDR_DBG: prot_nxt = pwdata[7:0];
            `FPS_ADDR_CMD: cmd_nxt = pwdata[7:0];
            `FPS_ADDR_DIV:
            begin
               div_nxt = pwdata[7:0];
               div_ld_nxt = 1'b1;
            end
            `FPS_ADDR_TGT: tgt_nxt = pwdata[15:0];
            `FPS_ADDR_CTL: dat_nxt = pwdata[7:0];
            `FPS_ADDR_STAT:
            begin
               if (pwdata[`FPS_ST_PVIOL])
                  stat_nxt[`FPS_ST_PVIOL] = 1'b0;
               if (pwdata[`FPS_ST_ACCERR])
                  stat_nxt[`FPS_ST_ACCERR] = 1'b0;
               if (pwdata[`FPS_ST_CBEF] && stat_r[`FPS_ST_CBEF])
                  launch = 1'b1;
            end
            default: ;
         endcase
      end

      if (launch)
      begin
         mass_or_blank = (dec == FPS_OP_MASS) || (dec == FPS_OP_BLANK);
         if (dec == FPS_OP_BAD)
            reject = 1'b1;
         else if (dec != FPS_OP_BLANK && !div_ld_r)
            reject = 1'b1;
         else if (state_r == FPS_BUSY
                  && !(dec == FPS_OP_BURST && op_r == FPS_OP_BURST))
            reject = 1'b1;
         else if (state_r == FPS_BUSY && pend_r)
            reject = 1'b1;
         if (reject)
            stat_nxt[`FPS_ST_ACCERR] = 1'b1;
         else if (prot_hit && dec != FPS_OP_BLANK
                  || mass_or_blank && dec == FPS_OP_MASS
                     && !prot_r[`FPS_PROT_DIS])
            stat_nxt[`FPS_ST_PVIOL] = 1'b1;
         else
         begin
            stat_nxt[`FPS_ST_BLANK] = 1'b0;
            stat_nxt[`FPS_ST_CCF] = 1'b0;
            if (state_r == FPS_BUSY)
            begin
               // Queued burst; buffer now full
               pend_nxt = 1'b1;
               pend_op_nxt = dec;
               pend_a_nxt = tgt_r;
               pend_d_nxt = dat_r;
               stat_nxt[`FPS_ST_CBEF] = 1'b0;
            end
            else
            begin
               state_nxt = FPS_BUSY;
               start_nxt = 1'b1;
               op_nxt = dec;
               a_nxt = (dec == FPS_OP_PAGE) ? (tgt_r & `FPS_PAGE_MASK)
                       : (dec == FPS_OP_BYTE || dec == FPS_OP_BURST)
                       ? tgt_r : `FPS_FLASH_BASE;
               d_nxt = dat_r;
               // Command goes straight to array, buffer frees again
               stat_nxt[`FPS_ST_CBEF] = 1'b1;
            end
         end
      end

      if (state_r == FPS_BUSY && stop_s2_r)
      begin
         // Stop aborts; buffered burst is lost too
         stat_nxt[`FPS_ST_ACCERR] = 1'b1;
         state_nxt = FPS_IDLE;
         pend_nxt = 1'b0;
         stat_nxt[`FPS_ST_CBEF] = 1'b1;
         stat_nxt[`FPS_ST_CCF] = 1'b1;
      end
      else if (state_r == FPS_BUSY && arr_done && !start_r)
      begin
         if (op_r == FPS_OP_BLANK && arr_blank_ok)
         begin
            stat_nxt[`FPS_ST_BLANK] = 1'b1;
            sec_nxt = `FPS_SEC_UNSECURE;
         end
         if (pend_r)
         begin
            // Transfer buffered burst to array
            pend_nxt = 1'b0;
            start_nxt = 1'b1;
            op_nxt = pend_op_r;
            a_nxt = pend_a_r;
            d_nxt = pend_d_r;
            stat_nxt[`FPS_ST_CBEF] = 1'b1;
         end
         else
         begin
            state_nxt = FPS_IDLE;
            if (stat_nxt[`FPS_ST_CBEF])
               stat_nxt[`FPS_ST_CCF] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= FPS_IDLE;
         load_r <= 1'b1;
         prot_r <= 8'h01;
         stat_r <= `FPS_STAT_RESET;
         cmd_code_reg <= 8'h00;
         div_r <= 8'h00;
         div_ld_r <= 1'b0;
         tgt_r <= 16'h0000;
         dat_r <= 8'h00;
         pend_r <= 1'b0;
         pend_op_r <= FPS_OP_BYTE;
         pend_a_r <= 16'h0000;
         pend_d_r <= 8'h00;
         start_r <= 1'b0;
         op_r <= FPS_OP_BYTE;
         a_r <= 16'h0000;
         d_r <= 8'h00;
         sec_r <= `FPS_SEC_RESET;
         rd_r <= 32'h0;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         load_r <= load_nxt;
         prot_r <= prot_nxt;
         stat_r <= stat_nxt;
         cmd_code_reg <= cmd_nxt;
         div_r <= div_nxt;
         div_ld_r <= div_ld_nxt;
         tgt_r <= tgt_nxt;
         dat_r <= dat_nxt;
         pend_r <= pend_nxt;
         pend_op_r <= pend_op_nxt;
         pend_a_r <= pend_a_nxt;
         pend_d_r <= pend_d_nxt;
         start_r <= start_nxt;
         op_r <= op_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         sec_r <= sec_nxt;
         rd_r <= rd_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata = rd_r;
   assign pready = rdy_r;
   assign pslverr = err_r;
   assign arr_start = start_r;
   assign arr_op = op_r;
   assign arr_addr = a_r;
   assign arr_data = d_r;
   assign security_state_code = sec_r;
endmodule

// *** hdl/fps_defs.svh ***
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// Register byte addresses
`define FPS_ADDR_PROT 12'h000
`define FPS_ADDR_STAT 12'h004
`define FPS_ADDR_CMD 12'h008
`define FPS_ADDR_DIV 12'h00c
`define FPS_ADDR_TGT 12'h010
`define FPS_ADDR_OPT 12'h014
`define FPS_ADDR_DBG 12'h018
`define FPS_ADDR_CTL 12'h01c

// Status bit positions
`define FPS_ST_CBEF 7
`define FPS_ST_CCF 6
`define FPS_ST_PVIOL 5
`define FPS_ST_ACCERR 4
`define FPS_ST_BLANK 2

// Protection field
`define FPS_PROT_DIS 0

// Command codes
`define FPS_CMD_BLANK 8'h05
`define FPS_CMD_BYTE 8'h20
`define FPS_CMD_BURST 8'h25
`define FPS_CMD_PAGE 8'h40
`define FPS_CMD_MASS 8'h41

// Security code
`define FPS_SEC_UNSECURE 2'h2
`define FPS_SEC_RESET 2'h0

// Page size mask, 512 bytes
`define FPS_PAGE_MASK 16'hfe00
// Flash array spans 0x8000 to 0xffff
`define FPS_FLASH_BASE 16'h8000
`define FPS_ERASED 8'hff
`define FPS_STAT_RESET 8'hc0

`endif

// *** hdl/fps_pkg.sv ***
package fps_pkg;
   typedef enum logic [2:0]
   {
      FPS_IDLE,
      FPS_BUSY
   } fps_state_type;

   typedef enum logic [2:0]
   {
      FPS_OP_BLANK,
      FPS_OP_BYTE,
      FPS_OP_BURST,
      FPS_OP_PAGE,
      FPS_OP_MASS,
      FPS_OP_BAD
   } fps_op_type;
endpackage

// *** tb/fps_flash_array.sv ***
`timescale 1ns/1ps
module fps_flash_array
(
   // Clock
   input wire logic pclk,
   // Controller side
   input wire logic arr_start,
   output logic arr_done,
   output logic arr_blank_ok,
   // Bench settings
   input wire logic [7:0] dly,
   input wire logic blank
);
   int cnt = 0;
   initial arr_done = 1'b0;
   always @(posedge pclk)
   begin
      arr_done <= 1'b0;
      if (arr_start)
         cnt <= dly;
      else if (cnt > 1)
         cnt <= cnt - 1;
      else if (cnt == 1)
      begin
         cnt <= 0;
         arr_done <= 1'b1;
      end
   end
   // Only valid with done; inverted otherwise so stale reads show
   assign arr_blank_ok = arr_done ? blank : ~blank;
endmodule

// *** tb/fps_flash_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_flash_ctrl_checker
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Array and security
   input wire logic arr_start,
   input wire fps_pkg::fps_op_type arr_op,
   input wire logic arr_done,
   input wire logic arr_blank_ok,
   input wire logic [1:0] security_state_code
);
   import fps_pkg::*;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic st_rd;
   assign st_rd = pready && !pwrite && paddr == `FPS_ADDR_STAT;
   answer_wait_a:
      assert property (psel && penable && !pready |=> pready)
      else $error("Late APB answer");
   answer_pulse_a:
      assert property (pready |=> !pready)
      else $error("Answer longer than one cycle");
   refused_zero_a:
      assert property (pslverr |-> pready && (pwrite || prdata == 0))
      else $error("Bad refused access");
   done_empty_a:
      assert property (st_rd && prdata[6] |-> prdata[7])
      else $error("Complete without empty buffer");
   blank_idle_a:
      assert property (st_rd && prdata[2] |-> prdata[6])
      else $error("Blank flag while busy");
   legal_op_a:
      assert property (arr_start |-> arr_op != FPS_OP_BAD)
      else $error("Illegal op started");
   single_start_a:
      assert property (arr_start |=> !arr_start && $stable(arr_op))
      else $error("Start not held apart");
   unlock_a:
      assert property (arr_done && arr_op == FPS_OP_BLANK && arr_blank_ok
         |=> security_state_code == `FPS_SEC_UNSECURE)
      else $error("No unlock after blank check");
   sec_cause_a:
      assert property ($changed(security_state_code) |-> $past(arr_blank_ok))
      else $error("Security changed without cause");
endmodule
bind fps_flash_ctrl fps_flash_ctrl_checker fps_flash_ctrl_checker_inst
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .arr_start(arr_start), .arr_op(arr_op),
   .arr_done(arr_done), .arr_blank_ok(arr_blank_ok),
   .security_state_code(security_state_code)
);

// *** tb/fps_flash_ctrl_test.sv ***
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_flash_ctrl_test;
   import fps_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, stop_req = 0, arr_start, arr_done, abo;
   logic blank = 1;
   logic [7:0] nvp = 8'hf0, dly = 8'd99, arr_data;
   logic [15:0] arr_addr, last_ad;
   logic [7:0] last_dt;
   logic [1:0] sec;
   fps_op_type arr_op, last_op;
   int n_fail = 0, n_compared = 0, n_start = 0, n0;
   logic [7:0] tc [4] = '{8'h05, 8'h20, 8'h40, 8'h25};
   logic [15:0] ta [4] = '{16'h8000, 16'hc0ff, 16'h8000, 16'h9001};
   logic [7:0] ts [4] = '{8'hc4, 8'hc0, 8'hc0, 8'hc0};
   fps_op_type to [4] = '{FPS_OP_BLANK, FPS_OP_BYTE, FPS_OP_PAGE, FPS_OP_BURST};
   always #5 pclk = ~pclk;
   always @(posedge pclk)
      if (arr_start)
      begin
         n_start <= n_start + 1;
         last_op <= arr_op;
         last_ad <= arr_addr;
         last_dt <= arr_data;
      end
   fps_flash_ctrl fps_flash_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nonvolatile_protect_byte(nvp), .stop_req(stop_req),
      .arr_start(arr_start), .arr_op(arr_op), .arr_addr(arr_addr),
      .arr_data(arr_data), .arr_done(arr_done), .arr_blank_ok(abo),
      .security_state_code(sec));
   fps_flash_array fps_flash_array_inst (.pclk(pclk), .arr_start(arr_start),
      .arr_done(arr_done), .arr_blank_ok(abo), .dly(dly), .blank(blank));
   task automatic end_sim();
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (i >= 50)
      begin
         n_fail++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(logic [11:0] a, logic [31:0] e, logic [31:0] m = 'hff);
      apb(1'b0, a, 0);
      chk(rd & m, e);
   endtask
   task automatic cmd(logic [7:0] c, logic [15:0] a);
      apb(1'b1, `FPS_ADDR_TGT, {16'h0, a});
      apb(1'b1, `FPS_ADDR_CTL, 32'h5a);
      apb(1'b1, `FPS_ADDR_CMD, {24'h0, c});
      apb(1'b1, `FPS_ADDR_STAT, 32'h80);
   endtask
   task automatic idle();
      int i;
      i = 0;
      do
      begin
         apb(1'b0, `FPS_ADDR_STAT, 0);
         i++;
      end
      while (rd[6] !== 1'b1 && i < 99);
      if (i >= 99)
      begin
         n_fail++;
         end_sim();
      end
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(`FPS_ADDR_PROT, 'hf0);
      rdc(`FPS_ADDR_STAT, 'hc0);
      apb(1'b1, `FPS_ADDR_PROT, 'hf8);
      rdc(`FPS_ADDR_PROT, 'hf0);
      apb(1'b1, `FPS_ADDR_PROT, 'h80);
      rdc(`FPS_ADDR_PROT, 'h80);
      cmd(`FPS_CMD_BYTE, 16'h9000);
      rdc(`FPS_ADDR_STAT, 'hd0);
      apb(1'b1, `FPS_ADDR_STAT, 'h00);
      rdc(`FPS_ADDR_STAT, 'hd0);
      apb(1'b1, `FPS_ADDR_STAT, 'h10);
      rdc(`FPS_ADDR_STAT, 'hc0);
      apb(1'b1, `FPS_ADDR_DIV, 'h13);
      for (int k = 0; k < 4; k++)
      begin
         cmd(tc[k], ta[k]);
         rdc(`FPS_ADDR_STAT, 'h00, 'h40);
         idle();
         rdc(`FPS_ADDR_STAT, {24'h0, ts[k]});
         chk(last_op, to[k]);
         chk(last_ad, ta[k]);
         chk(last_dt, 8'h5a);
      end
      rdc(`FPS_ADDR_OPT, `FPS_SEC_UNSECURE);
      n0 = n_start;
      cmd(`FPS_CMD_BYTE, 16'hc100);
      rdc(`FPS_ADDR_STAT, 'he0);
      cmd(`FPS_CMD_MASS, 16'h8000);
      chk(n_start, n0);
      apb(1'b1, `FPS_ADDR_STAT, 'h20);
      rdc(`FPS_ADDR_STAT, 'hc0);
      cmd(8'h33, 16'h9000);
      rdc(`FPS_ADDR_STAT, 'hd0);
      apb(1'b1, `FPS_ADDR_STAT, 'h10);
      apb(1'b1, `FPS_ADDR_DBG, 'hff);
      rdc(`FPS_ADDR_PROT, 'hff);
      apb(1'b1, `FPS_ADDR_PROT, 'h00);
      rdc(`FPS_ADDR_PROT, 'hff);
      // No blank check follows this erase
      cmd(`FPS_CMD_MASS, 16'h8000);
      idle();
      chk(last_op, FPS_OP_MASS);
      cmd(`FPS_CMD_BURST, 16'hf000);
      rdc(`FPS_ADDR_STAT, 'h80, 'hc0);
      cmd(`FPS_CMD_BYTE, 16'hf002);
      rdc(`FPS_ADDR_STAT, 'h10, 'h10);
      apb(1'b1, `FPS_ADDR_STAT, 'h10);
      cmd(`FPS_CMD_BURST, 16'hf001);
      rdc(`FPS_ADDR_STAT, 'h00, 'h80);
      idle();
      chk(last_ad, 16'hf001);
      apb(1'b0, 12'h100, 0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      cmd(`FPS_CMD_PAGE, 16'h8200);
      stop_req <= 1'b1;
      idle();
      stop_req <= 1'b0;
      rdc(`FPS_ADDR_STAT, 'hd0);
      end_sim();
   end
endmodule
